// ---- rtl/expander_params.svh ----
// constants for the two-wire port expander: address, offsets, reset values, timing
`ifndef EXPANDER_PARAMS_SVH
`define EXPANDER_PARAMS_SVH

// upper six bits of the 7-bit target address; the select pin supplies bit 0
`define TARGET_ADDR_BASE    6'h10

// command byte values that select a register
`define REG_INPUT_LEVELS    8'h00
`define REG_OUTPUT_LATCH    8'h01
`define REG_POLARITY        8'h02
`define REG_DIRECTION       8'h03

// command bits above the select field must be zero for a defined register
`define CMD_SEL_WIDTH       2

// power-up values
`define RST_OUTPUT_LATCH    8'hff
`define RST_POLARITY        8'h00
`define RST_DIRECTION       8'hff
`define RST_POINTER         8'h00

// link-side clear pulse after a start or stop, least time
`define SYS_CLOCK_MHZ       200
`define CLR_HOLD_NS         20
`define CLR_HOLD_CYCLES     ((`CLR_HOLD_NS * `SYS_CLOCK_MHZ + 999) / 1000)

`endif

// ---- rtl/expander_pkg.sv ----
// types shared by the port expander modules
package expander_pkg;

  typedef logic [7:0] byte_t;

  // gray-coded along address -> ack -> write -> ack, and between read and its ack
  typedef enum logic [2:0] {
    LINK_ADDR      = 3'h0,
    LINK_ADDR_ACK  = 3'h1,
    LINK_WRITE     = 3'h3,
    LINK_WRITE_ACK = 3'h2,
    LINK_READ      = 3'h6,
    LINK_READ_ACK  = 3'h7,
    LINK_IGNORE    = 3'h5
  } link_state_t;

endpackage

// ---- rtl/expander_core_if.sv ----
// bundle between the bus front end and the register core
`timescale 1ns/100ps
interface expander_core_if;
  logic                 wr_pulse;
  logic                 wr_is_cmd;
  expander_pkg::byte_t  wr_data;
  logic                 rd_pulse;
  expander_pkg::byte_t  pins;
  expander_pkg::byte_t  rd_data;
  expander_pkg::byte_t  pointer;
  expander_pkg::byte_t  out_latch;
  expander_pkg::byte_t  polarity;
  expander_pkg::byte_t  port_oe;

  modport core (
    input  wr_pulse, wr_is_cmd, wr_data, rd_pulse, pins,
    output rd_data, pointer, out_latch, polarity, port_oe
  );
  modport front (
    output wr_pulse, wr_is_cmd, wr_data, rd_pulse, pins,
    input  rd_data, pointer, out_latch, polarity, port_oe
  );
endinterface // expander_core_if

// ---- rtl/bit_sync.sv ----
// two flip-flop synchroniser, no reset so pin levels carry no fixed value
`timescale 1ns/100ps
module bit_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clock,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge i_clock) begin
    meta_q <= i_async;
    o_sync <= meta_q;
  end
endmodule // bit_sync

// ---- rtl/expander_reg_core.sv ----
// register file and command decode of the port expander
`timescale 1ns/100ps
`include "expander_params.svh"
module expander_reg_core (
  input  wire logic      i_clock,
  input  wire logic      i_rst,
  expander_core_if.core  bus
);
  function automatic logic is_defined(input expander_pkg::byte_t cmd);
    return cmd[7:`CMD_SEL_WIDTH] == 6'h00;
  endfunction

  logic wr_hit;
  assign wr_hit = bus.wr_pulse && !bus.wr_is_cmd && is_defined(bus.pointer);

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      bus.pointer <= `RST_POINTER;
    end else if (bus.wr_pulse && bus.wr_is_cmd) begin
      bus.pointer <= bus.wr_data;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      bus.out_latch <= `RST_OUTPUT_LATCH;
      bus.polarity  <= `RST_POLARITY;
      bus.port_oe   <= ~`RST_DIRECTION;
    end else if (wr_hit) begin
      // input levels take no write data
      case (bus.pointer)
        `REG_OUTPUT_LATCH: bus.out_latch <= bus.wr_data;
        `REG_POLARITY:     bus.polarity  <= bus.wr_data;
        `REG_DIRECTION:    bus.port_oe   <= ~bus.wr_data;
        default:           bus.out_latch <= bus.out_latch;
      endcase
    end
  end

  // an undefined command reads back the pointer itself
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      bus.rd_data <= 8'h00;
    end else if (bus.rd_pulse) begin
      if (!is_defined(bus.pointer)) begin
        bus.rd_data <= bus.pointer;
      end else begin
        case (bus.pointer)
          `REG_INPUT_LEVELS: bus.rd_data <= bus.pins ^ bus.polarity;
          `REG_OUTPUT_LATCH: bus.rd_data <= bus.out_latch;
          `REG_POLARITY:     bus.rd_data <= bus.polarity;
          default:           bus.rd_data <= ~bus.port_oe;
        endcase
      end
    end
  end
endmodule // expander_reg_core

// ---- rtl/i2c_gpio_expander_regs.sv ----
// two-wire target front end and top level of the 8-bit port expander
//
// Notes on behaviour
// - first byte after an acknowledged write address is stored as the pointer
// - the command byte selects input, latch, polarity or direction register
// - pointer is writable and reads back when its upper bits are nonzero
// - input register reads give the pin levels, for inputs and outputs alike
// - writes to the input register change nothing
// - output pins follow the latch; latch bits of input pins do nothing
// - latch reads give the stored value, not the pin level
// - latch and direction reset to all ones, so every pin starts as input
// - a polarity bit of one inverts the reported pin level
// - a polarity bit of zero reports the level as is; all reset to zero
// - direction one releases the pin driver, zero enables it
// - input register has no reset value and follows the pins
// - target address is 0x20 or 0x21, chosen by the address-select pin
// - last address bit one means read, zero means write
// - reset puts registers and the bus state machine in their defaults
`timescale 1ns/100ps
`include "expander_params.svh"
module i2c_gpio_expander_regs (
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda_out,
  output logic            o_sda_oe,
  input  wire logic       i_addr_sel,
  input  wire logic [7:0] i_port_in,
  output logic      [7:0] o_port_out,
  output logic      [7:0] o_port_oe,
  output logic      [7:0] o_register_pointer
);
  localparam int CLR_CYCLES = `CLR_HOLD_CYCLES;

  expander_core_if core_bus ();

  // ------------------------------------------------------------------
  // system-clock side: start/stop detection and event crossing
  // ------------------------------------------------------------------
  logic       scl_s;
  logic       sda_s;
  logic       sda_prev_q;
  logic       start_det;
  logic       stop_det;
  logic       link_clr_q;
  logic [3:0] clr_cnt_q;
  logic       wr_tgl_q;
  logic       rd_tgl_q;
  logic       wr_tgl_s;
  logic       rd_tgl_s;
  logic       wr_tgl_prev_q;
  logic       rd_tgl_prev_q;
  logic       sda_out_q;

  bit_sync #(.WIDTH(2)) line_sync (
    .i_clock (i_clock),
    .i_async ({i_scl, i_sda}),
    .o_sync  ({scl_s, sda_s})
  );

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      sda_prev_q <= 1'h1;
    end else begin
      sda_prev_q <= sda_s;
    end
  end

  assign start_det = scl_s && sda_prev_q && !sda_s;
  assign stop_det  = scl_s && !sda_prev_q && sda_s;

  // clear is held briefly; scl stays put for far longer after start or stop
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      link_clr_q <= 1'h0;
      clr_cnt_q  <= 4'h0;
    end else if (start_det || stop_det) begin
      link_clr_q <= 1'h1;
      clr_cnt_q  <= 4'(CLR_CYCLES - 1);
    end else if (clr_cnt_q != 4'h0) begin
      clr_cnt_q  <= clr_cnt_q - 4'h1;
    end else begin
      link_clr_q <= 1'h0;
    end
  end

  bit_sync #(.WIDTH(2)) tgl_sync (
    .i_clock (i_clock),
    .i_async ({wr_tgl_q, rd_tgl_q}),
    .o_sync  ({wr_tgl_s, rd_tgl_s})
  );

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      wr_tgl_prev_q <= 1'h0;
      rd_tgl_prev_q <= 1'h0;
    end else begin
      wr_tgl_prev_q <= wr_tgl_s;
      rd_tgl_prev_q <= rd_tgl_s;
    end
  end

  bit_sync #(.WIDTH(8)) pin_sync (
    .i_clock (i_clock),
    .i_async (i_port_in),
    .o_sync  (core_bus.pins)
  );

  // open-drain data line only ever pulls low
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      sda_out_q <= 1'h0;
    end else begin
      sda_out_q <= 1'h0;
    end
  end

  // ------------------------------------------------------------------
  // link side, clocked by scl
  // ------------------------------------------------------------------
  expander_pkg::link_state_t state_q;
  logic [2:0]          bit_cnt_q;
  logic [6:0]          shift_q;
  logic [6:0]          tx_q;
  logic                rw_q;
  logic                first_q;
  logic                sda_oe_q;
  logic                wr_is_cmd_q;
  expander_pkg::byte_t wr_data_q;
  expander_pkg::byte_t rx_byte;
  logic                addr_sel_s;
  logic                addr_hit;
  logic                link_rst;
  logic                byte_end;

  // a glitch here only clears the link early; sources are both flops
  assign link_rst = i_rst || link_clr_q;
  assign rx_byte  = {shift_q, i_sda};
  assign byte_end = bit_cnt_q == 3'h7;
  assign addr_hit = rx_byte[7:1] == {`TARGET_ADDR_BASE, addr_sel_s};

  bit_sync #(.WIDTH(1)) addr_sync (
    .i_clock (i_scl),
    .i_async (i_addr_sel),
    .o_sync  (addr_sel_s)
  );

  always_ff @(posedge i_scl or posedge link_rst) begin
    if (link_rst) begin
      state_q   <= expander_pkg::LINK_ADDR;
      bit_cnt_q <= 3'h0;
    end else begin
      case (state_q)
        expander_pkg::LINK_ADDR: begin
          bit_cnt_q <= bit_cnt_q + 3'h1;
          if (byte_end) begin
            state_q <= addr_hit ? expander_pkg::LINK_ADDR_ACK : expander_pkg::LINK_IGNORE;
          end
        end
        expander_pkg::LINK_ADDR_ACK: begin
          bit_cnt_q <= 3'h0;
          state_q   <= rw_q ? expander_pkg::LINK_READ : expander_pkg::LINK_WRITE;
        end
        expander_pkg::LINK_WRITE: begin
          bit_cnt_q <= bit_cnt_q + 3'h1;
          if (byte_end) begin
            state_q <= expander_pkg::LINK_WRITE_ACK;
          end
        end
        expander_pkg::LINK_WRITE_ACK: begin
          bit_cnt_q <= 3'h0;
          state_q   <= expander_pkg::LINK_WRITE;
        end
        expander_pkg::LINK_READ: begin
          bit_cnt_q <= bit_cnt_q + 3'h1;
          if (byte_end) begin
            state_q <= expander_pkg::LINK_READ_ACK;
          end
        end
        expander_pkg::LINK_READ_ACK: begin
          bit_cnt_q <= 3'h0;
          // a nack ends the read until the next start
          state_q   <= i_sda ? expander_pkg::LINK_IGNORE : expander_pkg::LINK_READ;
        end
        default: begin
          state_q <= expander_pkg::LINK_IGNORE;
        end
      endcase
    end
  end

  always_ff @(posedge i_scl or posedge link_rst) begin
    if (link_rst) begin
      shift_q <= 7'h00;
    end else begin
      shift_q <= rx_byte[6:0];
    end
  end

  always_ff @(posedge i_scl or posedge link_rst) begin
    if (link_rst) begin
      rw_q    <= 1'h0;
      first_q <= 1'h0;
    end else if (state_q == expander_pkg::LINK_ADDR && byte_end) begin
      rw_q    <= i_sda;
      first_q <= 1'h1;
    end else if (state_q == expander_pkg::LINK_WRITE && byte_end) begin
      first_q <= 1'h0;
    end
  end

  // toggles survive the per-frame clear so the far side sees no false edge
  always_ff @(posedge i_scl or posedge i_rst) begin
    if (i_rst) begin
      wr_tgl_q    <= 1'h0;
      wr_is_cmd_q <= 1'h0;
      wr_data_q   <= 8'h00;
    end else if (state_q == expander_pkg::LINK_WRITE && byte_end) begin
      wr_tgl_q    <= ~wr_tgl_q;
      wr_is_cmd_q <= first_q;
      wr_data_q   <= rx_byte;
    end
  end

  // read request on the ack clock; data is needed half a period later
  always_ff @(posedge i_scl or posedge i_rst) begin
    if (i_rst) begin
      rd_tgl_q <= 1'h0;
    end else if ((state_q == expander_pkg::LINK_ADDR_ACK && rw_q) ||
                 (state_q == expander_pkg::LINK_READ_ACK && !i_sda)) begin
      rd_tgl_q <= ~rd_tgl_q;
    end
  end

  always_ff @(negedge i_scl or posedge link_rst) begin
    if (link_rst) begin
      sda_oe_q <= 1'h0;
      tx_q     <= 7'h00;
    end else begin
      case (state_q)
        expander_pkg::LINK_ADDR_ACK,
        expander_pkg::LINK_WRITE_ACK: begin
          sda_oe_q <= 1'h1;
        end
        expander_pkg::LINK_READ: begin
          if (bit_cnt_q == 3'h0) begin
            sda_oe_q <= ~core_bus.rd_data[7];
            tx_q     <= core_bus.rd_data[6:0];
          end else begin
            sda_oe_q <= ~tx_q[6];
            tx_q     <= {tx_q[5:0], 1'h0};
          end
        end
        default: begin
          sda_oe_q <= 1'h0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // register core and outputs
  // ------------------------------------------------------------------
  assign core_bus.wr_pulse  = wr_tgl_s ^ wr_tgl_prev_q;
  assign core_bus.rd_pulse  = rd_tgl_s ^ rd_tgl_prev_q;
  // link data stays still for a whole byte after its toggle flips
  assign core_bus.wr_is_cmd = wr_is_cmd_q;
  assign core_bus.wr_data   = wr_data_q;

  expander_reg_core reg_core (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .bus     (core_bus)
  );

  assign o_sda_out          = sda_out_q;
  assign o_sda_oe           = sda_oe_q;
  assign o_port_out         = core_bus.out_latch;
  assign o_port_oe          = core_bus.port_oe;
  assign o_register_pointer = core_bus.pointer;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  cmd_store_a: assert property (@(posedge i_clock) disable iff (i_rst)
    core_bus.wr_pulse && core_bus.wr_is_cmd |=> o_register_pointer == $past(wr_data_q))
    else $error("command byte not stored in pointer");

  latch_write_a: assert property (@(posedge i_clock) disable iff (i_rst)
    core_bus.wr_pulse && !core_bus.wr_is_cmd && o_register_pointer == `REG_OUTPUT_LATCH
    |=> o_port_out == $past(wr_data_q))
    else $error("latch write not seen on port");

  dir_write_a: assert property (@(posedge i_clock) disable iff (i_rst)
    core_bus.wr_pulse && !core_bus.wr_is_cmd && o_register_pointer == `REG_DIRECTION
    |=> o_port_oe == ~$past(wr_data_q))
    else $error("direction write not seen on enables");

  input_ignore_a: assert property (@(posedge i_clock) disable iff (i_rst)
    core_bus.wr_pulse && !core_bus.wr_is_cmd && o_register_pointer == `REG_INPUT_LEVELS
    |=> $stable(o_port_out) && $stable(o_port_oe) && $stable(core_bus.polarity))
    else $error("input register write changed state");

  undef_ignore_a: assert property (@(posedge i_clock) disable iff (i_rst)
    core_bus.wr_pulse && !core_bus.wr_is_cmd && o_register_pointer[7:2] != 6'h00
    |=> $stable(o_port_out) && $stable(o_port_oe) && $stable(core_bus.polarity))
    else $error("undefined command write changed state");

  read_input_a: assert property (@(posedge i_clock) disable iff (i_rst)
    core_bus.rd_pulse && o_register_pointer == `REG_INPUT_LEVELS
    |=> core_bus.rd_data == $past(core_bus.pins ^ core_bus.polarity))
    else $error("input read does not match pins");

  read_latch_a: assert property (@(posedge i_clock) disable iff (i_rst)
    core_bus.rd_pulse && o_register_pointer == `REG_OUTPUT_LATCH
    |=> core_bus.rd_data == $past(o_port_out))
    else $error("latch read does not match latch");

  pointer_read_a: assert property (@(posedge i_clock) disable iff (i_rst)
    core_bus.rd_pulse && o_register_pointer[7:2] != 6'h00
    |=> core_bus.rd_data == $past(o_register_pointer))
    else $error("pointer not read back");

  reset_values_a: assert property (@(posedge i_clock)
    i_rst |-> o_port_out == `RST_OUTPUT_LATCH && o_port_oe == 8'h00
              && core_bus.polarity == `RST_POLARITY && !o_sda_oe)
    else $error("reset values wrong");

  frame_clear_a: assert property (@(posedge i_clock) disable iff (i_rst)
    start_det |=> link_clr_q [*4])
    else $error("start did not clear the link");

  addr_match_a: assert property (@(posedge i_scl) disable iff (link_rst)
    state_q == expander_pkg::LINK_ADDR && byte_end
    |=> state_q == ($past(addr_hit) ? expander_pkg::LINK_ADDR_ACK : expander_pkg::LINK_IGNORE))
    else $error("address decode wrong");

  rw_decode_a: assert property (@(posedge i_scl) disable iff (link_rst)
    state_q == expander_pkg::LINK_ADDR_ACK
    |=> state_q == ($past(rw_q) ? expander_pkg::LINK_READ : expander_pkg::LINK_WRITE))
    else $error("read/write bit decoded wrong");

endmodule // i2c_gpio_expander_regs

// ---- testbench/i2c_ctrl_model.sv ----
// two-wire bus controller model driving the expander's link side
`timescale 1ns/100ps
module i2c_ctrl_model #(
  parameter realtime QTR = 15.3
) (
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  // scl high spans two quarters (about 30 ns) so read data has settled
  // quarter sits off the 5 ns grid so scl edges drift against the system clock
  initial begin
    o_scl     = 1'b1;
    o_sda_low = 1'b0;
  end

  // also serves as repeated start; scl stands still between frames
  task automatic start_cond();
    o_sda_low = 1'b0;
    #(QTR) o_scl = 1'b1;
    #(2*QTR) o_sda_low = 1'b1;
    #(2*QTR) o_scl = 1'b0;
    #(QTR);
  endtask

  task automatic stop_cond();
    o_sda_low = 1'b1;
    #(QTR) o_scl = 1'b1;
    #(2*QTR) o_sda_low = 1'b0;
    #(2*QTR);
  endtask

  // data changes only while scl is low
  task automatic bit_cycle(input logic drive_low, output logic seen);
    o_sda_low = drive_low;
    #(QTR) o_scl = 1'b1;
    #(QTR) seen = i_sda;
    #(QTR) o_scl = 1'b0;
    #(QTR);
  endtask

  task automatic write_byte(input expander_pkg::byte_t b, output logic ack_n);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(~b[i], s);
    end
    bit_cycle(1'b0, ack_n);
  endtask

  task automatic read_byte(input logic last, output expander_pkg::byte_t b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b0, b[i]);
    end
    bit_cycle(~last, s);
  endtask
endmodule // i2c_ctrl_model

// ---- testbench/testbench.sv ----
// self-checking bench for the two-wire port expander
`timescale 1ns/100ps
`include "expander_params.svh"
module testbench;
  localparam int WDOG = 80000;
  logic                i_clock;
  logic                i_rst;
  logic                i_addr_sel;
  logic                scl;
  logic                sda_low;
  logic                sda_wire;
  logic                o_sda_out;
  logic                o_sda_oe;
  logic [7:0]          i_port_in;
  logic [7:0]          o_port_out;
  logic [7:0]          o_port_oe;
  logic [7:0]          o_register_pointer;
  expander_pkg::byte_t m_latch, m_pol, m_dir, m_ptr, ext_q;
  logic [31:0]         lfsr_q;
  int                  err_total;
  int                  n_checks;

  // open-drain wire with pull-up
  assign sda_wire = ~(sda_low | (o_sda_oe & ~o_sda_out));

  initial i_clock = 1'b0;
  always #2.5 i_clock = ~i_clock;

  // pins driven by the device where enabled, else by the outside world
  always @(posedge i_clock) i_port_in <= (o_port_out & o_port_oe) | (ext_q & ~o_port_oe);

  i2c_gpio_expander_regs dut (
    .i_clock(i_clock), .i_rst(i_rst), .i_scl(scl), .i_sda(sda_wire),
    .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .i_addr_sel(i_addr_sel),
    .i_port_in(i_port_in), .o_port_out(o_port_out), .o_port_oe(o_port_oe),
    .o_register_pointer(o_register_pointer)
  );

  i2c_ctrl_model ctrl (.i_sda(sda_wire), .o_scl(scl), .o_sda_low(sda_low));

  function automatic logic [31:0] lfsr_next(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic expander_pkg::byte_t rd_exp(expander_pkg::byte_t p);
    case (p)
      `REG_INPUT_LEVELS: return ((m_latch & ~m_dir) | (ext_q & m_dir)) ^ m_pol;
      `REG_OUTPUT_LATCH: return m_latch;
      `REG_POLARITY:     return m_pol;
      `REG_DIRECTION:    return m_dir;
      default:           return p;
    endcase
  endfunction

  task automatic give_verdict();
    if (err_total == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rst_model();
    m_latch = `RST_OUTPUT_LATCH;
    m_pol   = `RST_POLARITY;
    m_dir   = `RST_DIRECTION;
    m_ptr   = `RST_POINTER;
  endtask

  task automatic check_ports();
    check(o_port_out, m_latch);
    check(o_port_oe, ~m_dir);
    check(o_register_pointer, m_ptr);
  endtask

  // command byte, then optional data to the selected register
  task automatic wr(input expander_pkg::byte_t p, input expander_pkg::byte_t d, input bit dat);
    logic a;
    ctrl.start_cond();
    ctrl.write_byte({`TARGET_ADDR_BASE, i_addr_sel, 1'b0}, a);
    check({7'h00, a}, 8'h00);
    ctrl.write_byte(p, a);
    m_ptr = p;
    if (dat) begin
      ctrl.write_byte(d, a);
      case (p)
        `REG_OUTPUT_LATCH: m_latch = d;
        `REG_POLARITY:     m_pol = d;
        `REG_DIRECTION:    m_dir = d;
        default:           m_ptr = p;
      endcase
    end
    ctrl.stop_cond();
    repeat (4) @(posedge i_clock);
  endtask

  // read n bytes under the stored pointer, acking all but the last
  task automatic rd_chk(input int n);
    expander_pkg::byte_t b;
    logic                a;
    ctrl.start_cond();
    ctrl.write_byte({`TARGET_ADDR_BASE, i_addr_sel, 1'b1}, a);
    check({7'h00, a}, 8'h00);
    for (int k = 0; k < n; k++) begin
      ctrl.read_byte(k == n - 1, b);
      check(b, rd_exp(m_ptr));
    end
    ctrl.stop_cond();
  endtask

  task automatic read_all(input int n);
    for (int p = 0; p < 4; p++) begin
      wr(p[7:0], 8'h00, 1'b0);
      rd_chk(n);
    end
  endtask

  task automatic addr_probe(input logic bit0, input logic exp_nack);
    logic a;
    ctrl.start_cond();
    ctrl.write_byte({`TARGET_ADDR_BASE, bit0, 1'b0}, a);
    check({7'h00, a}, {7'h00, exp_nack});
    ctrl.stop_cond();
  endtask

  task automatic do_reset();
    @(posedge i_clock);
    i_rst <= 1'b1;
    repeat (5) @(posedge i_clock);
    i_rst <= 1'b0;
    rst_model();
    repeat (4) @(posedge i_clock);
  endtask

  initial begin
    repeat (WDOG) @(posedge i_clock);
    err_total++;
    give_verdict();
  end

  initial begin
    i_rst      = 1'b0;
    i_addr_sel = 1'b0;
    i_port_in  = 8'h00;
    ext_q      = 8'h5a;
    lfsr_q     = 32'h87ff47dc;
    err_total  = 0;
    n_checks   = 0;
    rst_model();
    // a real rising edge, so the async resets fire before the first clock
    #1 i_rst = 1'b1;
    repeat (5) @(posedge i_clock);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_clock);
    check_ports();
    read_all(1);
    for (int k = 0; k < 10; k++) begin
      lfsr_q = lfsr_next(lfsr_q);
      if (k == 0) lfsr_q = 32'hff_a5_00_3c;  // all outputs, full inversion
      if (k == 1) lfsr_q = 32'h0f_00_ff_c3;  // all inputs, latch cleared
      @(posedge i_clock);
      ext_q <= lfsr_q[7:0];
      wr(`REG_DIRECTION, lfsr_q[15:8], 1'b1);
      wr(`REG_OUTPUT_LATCH, lfsr_q[23:16], 1'b1);
      wr(`REG_POLARITY, lfsr_q[31:24], 1'b1);
      check_ports();
      read_all(2);
    end
    // input register and undefined commands ignore data
    wr(`REG_INPUT_LEVELS, ~m_latch, 1'b1);
    check_ports();
    rd_chk(1);
    wr(8'h81, ~m_latch, 1'b1);
    check_ports();
    rd_chk(1);
    wr(8'hfe, ~m_dir, 1'b1);
    check_ports();
    // address follows the select strap
    addr_probe(1'b1, 1'b1);
    @(posedge i_clock);
    i_addr_sel <= 1'b1;
    repeat (4) @(posedge i_clock);
    addr_probe(1'b0, 1'b1);
    wr(`REG_OUTPUT_LATCH, 8'h96, 1'b1);
    rd_chk(1);
    do_reset();
    check_ports();
    read_all(1);
    give_verdict();
  end
endmodule // testbench
